// ---- core/txo_pkg.sv ----
package txo_pkg;
    // instruction word layout
    localparam int INSN_W = 12;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 5;
    localparam int DIR_SEL_W = 3;
    localparam int DEST_BIT = 5;
    localparam int ZERO_BIT = 2;
    // opcode patterns and masks
    localparam logic [11:0] DIR_MASK = 12'hff8;
    localparam logic [11:0] DIR_PAT = 12'h000;
    localparam logic [11:0] XLIT_MASK = 12'hf00;
    localparam logic [11:0] XLIT_PAT = 12'hf00;
    localparam logic [11:0] XFILE_MASK = 12'hfc0;
    localparam logic [11:0] XFILE_PAT = 12'h180;
    // direction targets
    localparam logic [2:0] DIR_FIRST = 3'h6;
    localparam logic [2:0] DIR_SECOND = 3'h7;
    // reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'hff;
    // one instruction cycle per instruction
    localparam int EXEC_CYCLES = 1;
    // file-read latency of the register memory
    localparam int FREAD_LAT = 1;
endpackage : txo_pkg

// ---- core/txo_dir_mem.sv ----
`timescale 1ns/10ps
`default_nettype none
module txo_dir_mem #(
    parameter int DATA_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic we,
    input wire logic sel,
    input wire logic [DATA_W-1:0] wdata,
    output logic [DATA_W-1:0] dir0,
    output logic [DATA_W-1:0] dir1
);
    // the reset value is a full byte, so narrower words cannot hold it
    if (DATA_W != 8) begin : g_bad_width
        $error("txo_dir_mem serves only 8-bit data");
    end

    // two direction words, read straight from the registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dir0 <= txo_pkg::DIR_RST;
            dir1 <= txo_pkg::DIR_RST;
        end else if (ce && we) begin
            if (sel) begin
                dir1 <= wdata;
            end else begin
                dir0 <= wdata;
            end
        end
    end
endmodule : txo_dir_mem
`default_nettype wire

// ---- core/txo_core.sv ----
`timescale 1ns/10ps
`default_nettype none
module txo_core #(
    parameter int DATA_W = 8
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic INSN_VALID,
    input wire logic [11:0] INSN,
    input wire logic [DATA_W-1:0] FILE_RDATA,
    input wire logic [DATA_W-1:0] STATUS_IN,
    output logic [DATA_W-1:0] ACC,
    output logic [4:0] FILE_ADDR,
    output logic [DATA_W-1:0] FILE_WDATA,
    output logic FILE_WE,
    output logic ZERO_FLAG,
    output logic ZERO_WE,
    output logic [DATA_W-1:0] DIR_FIRST_PORT,
    output logic [DATA_W-1:0] SECOND_IO_PORT_DIR,
    output logic ILLEGAL
);
    // opcodes and the zero test are fixed to a byte-wide accumulator
    if (DATA_W != 8) begin : g_bad_width
        $error("txo_core serves only 8-bit data");
    end

    ////////////////////////////////////////////////////////////////////
    // decode; FILE_RDATA is the contents of the file named by INSN[4:0]
    // the three opcode groups are disjoint in their top bits, so the
    // priority below never changes the outcome, even for a malformed or unknown word;
    // anything that matches no group writes no accumulator, file or direction register
    typedef enum {TXO_NONE, TXO_DIR, TXO_XLIT, TXO_XFILE} txo_op_e;

    // mask-and-compare shared by every opcode group
    function automatic logic txo_match(input logic [11:0] word, input logic [11:0] mask,
        input logic [11:0] pat);
        return (word & mask) == pat;
    endfunction : txo_match

    wire logic is_dir = txo_match(INSN, txo_pkg::DIR_MASK, txo_pkg::DIR_PAT);
    wire logic [2:0] dir_sel = INSN[2:0];
    wire logic dir_ok = (dir_sel == txo_pkg::DIR_FIRST) || (dir_sel == txo_pkg::DIR_SECOND);
    wire logic is_xlit = txo_match(INSN, txo_pkg::XLIT_MASK, txo_pkg::XLIT_PAT);
    wire logic is_xfile = txo_match(INSN, txo_pkg::XFILE_MASK, txo_pkg::XFILE_PAT);
    wire logic dest_file = INSN[txo_pkg::DEST_BIT];
    wire logic [4:0] faddr = INSN[4:0];
    txo_op_e op;
    always_comb begin
        op = TXO_NONE;
        if (INSN_VALID && is_dir && dir_ok) op = TXO_DIR;
        else if (INSN_VALID && is_xlit) op = TXO_XLIT;
        else if (INSN_VALID && is_xfile) op = TXO_XFILE;
    end

    ////////////////////////////////////////////////////////////////////
    // datapath: xor operand chosen by instruction kind
    wire logic [7:0] operand = (op == TXO_XLIT) ? INSN[7:0] : FILE_RDATA;
    wire logic [7:0] result = ACC ^ operand;
    wire logic res_zero = (result == 8'h00);
    wire logic do_xor = (op == TXO_XLIT) || (op == TXO_XFILE);
    wire logic acc_load = (op == TXO_XLIT) || (op == TXO_XFILE && !dest_file);
    wire logic file_load = (op == TXO_XFILE) && dest_file;
    wire logic dir_load = (op == TXO_DIR);
    wire logic bad_dir = INSN_VALID && is_dir && !dir_ok && (INSN != 12'h000);

    logic [7:0] acc_next;
    assign acc_next = acc_load ? result : ACC;

    // accumulator, zero flag and file write port; single cycle each
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ACC <= txo_pkg::ACC_RST;
            ZERO_FLAG <= 1'b0;
            ZERO_WE <= 1'b0;
            FILE_WE <= 1'b0;
            FILE_ADDR <= 5'h00;
            FILE_WDATA <= 8'h00;
            ILLEGAL <= 1'b0;
        end else if (CE) begin
            ACC <= acc_next;
            // only zero is written; other status bits keep their value
            ZERO_FLAG <= do_xor ? res_zero : STATUS_IN[txo_pkg::ZERO_BIT];
            ZERO_WE <= do_xor;
            FILE_WE <= file_load;
            FILE_ADDR <= faddr;
            FILE_WDATA <= result;
            ILLEGAL <= bad_dir;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // direction registers live in their own little memory
    txo_dir_mem #(.DATA_W(DATA_W)) u_dir (
        .clk(CLK),
        .rst_n(RST_N),
        .ce(CE),
        .we(dir_load),
        .sel(dir_sel[0]),
        .wdata(ACC),
        .dir0(DIR_FIRST_PORT),
        .dir1(SECOND_IO_PORT_DIR)
    );

    ////////////////////////////////////////////////////////////////////
    // checks
    sequence s_dir_issue;
        CE && INSN_VALID && is_dir && dir_sel == 3'h7;
    endsequence
    a_dir_copies_acc: assert property (@(posedge CLK) disable iff (!RST_N)
        s_dir_issue |=> SECOND_IO_PORT_DIR == $past(ACC) && !ZERO_WE)
        else $error("direction load did not copy accumulator");
    a_dir_bad_target: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && INSN_VALID && is_dir && !dir_ok |=> $stable(DIR_FIRST_PORT)
            && $stable(SECOND_IO_PORT_DIR))
        else $error("invalid direction target changed a register");
    a_xlit_result: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && INSN_VALID && is_xlit |=> ACC == ($past(ACC) ^ $past(INSN[7:0])))
        else $error("literal xor result wrong");
    a_xfile_acc: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && op == TXO_XFILE && !dest_file |=> ACC == ($past(ACC) ^ $past(FILE_RDATA)))
        else $error("file xor into accumulator wrong");
    a_xfile_dest: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && op == TXO_XFILE && dest_file |=> FILE_WE && $stable(ACC)
            && FILE_ADDR == $past(INSN[4:0]))
        else $error("file xor write-back wrong");
    a_xlit_nofile: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && op == TXO_XLIT |=> !FILE_WE)
        else $error("literal xor wrote a file register");
    // the result lands in the file port or the accumulator, never both
    a_zero_flag: assert property (@(posedge CLK) disable iff (!RST_N)
        ZERO_WE |-> ZERO_FLAG == ((FILE_WE ? FILE_WDATA : ACC) == 8'h00))
        else $error("zero flag mismatch");

    ////////////////////////////////////////////////////////////////////
    // further checks, built from the issue sequences below except a_dir_quiet and a_illegal_pulse
    sequence s_dir_first_issue;
        CE && INSN_VALID && is_dir && dir_sel == 3'h6;
    endsequence
    sequence s_xfile_issue;
        CE && op == TXO_XFILE;
    endsequence
    sequence s_no_xor;
        CE && !do_xor;
    endsequence
    sequence s_idle;
        CE && !INSN_VALID;
    endsequence
    sequence s_frozen;
        !CE;
    endsequence

    // target six must take the accumulator and leave seven alone
    a_dir_first_copy: assert property (@(posedge CLK) disable iff (!RST_N)
        s_dir_first_issue |=> DIR_FIRST_PORT == $past(ACC) && $stable(SECOND_IO_PORT_DIR))
        else $error("direction load to first target wrong");

    // a direction load touches no flag, no file and no accumulator
    a_dir_quiet: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && op == TXO_DIR |=> !ZERO_WE && !FILE_WE && $stable(ACC))
        else $error("direction load had a side effect");

    // bad target pulses the illegal flag for one enabled cycle
    a_illegal_pulse: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && INSN_VALID && is_dir && !dir_ok && dir_sel != 3'h0 |=> ILLEGAL)
        else $error("bad direction target not flagged");

    // file xor puts the file address and the xor result on the file port, either destination
    a_xfile_port: assert property (@(posedge CLK) disable iff (!RST_N)
        s_xfile_issue |=> FILE_ADDR == $past(faddr)
            && FILE_WDATA == ($past(ACC) ^ $past(FILE_RDATA)))
        else $error("file xor address or data wrong");

    // zero follows the result of a file xor, whichever destination
    a_xfile_zero: assert property (@(posedge CLK) disable iff (!RST_N)
        s_xfile_issue |=> ZERO_WE && ZERO_FLAG == (($past(ACC) ^ $past(FILE_RDATA)) == 8'h00))
        else $error("file xor zero flag wrong");

    // status passes through untouched when no xor runs
    a_status_pass: assert property (@(posedge CLK) disable iff (!RST_N)
        s_no_xor |=> !ZERO_WE && ZERO_FLAG == $past(STATUS_IN[txo_pkg::ZERO_BIT]))
        else $error("zero flag not passed through");

    // no valid instruction means no write of any kind
    a_idle_quiet: assert property (@(posedge CLK) disable iff (!RST_N)
        s_idle |=> !FILE_WE && !ZERO_WE && !ILLEGAL && $stable(ACC))
        else $error("idle cycle wrote something");

    // clock enable low freezes every register of the block
    a_ce_freeze: assert property (@(posedge CLK) disable iff (!RST_N)
        s_frozen |=> $stable(ACC) && $stable(FILE_WE) && $stable(ZERO_WE)
            && $stable(ZERO_FLAG) && $stable(ILLEGAL) && $stable(DIR_FIRST_PORT)
            && $stable(SECOND_IO_PORT_DIR))
        else $error("state moved while clock enable was low");
endmodule : txo_core
`default_nettype wire

// ---- verif/txo_core_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module txo_core_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic ce_mix = 1'b0;
    logic insn_valid = 1'b0;
    logic [11:0] insn = 12'h000;
    logic [7:0] file_rdata = 8'h00;
    logic [7:0] status_in = 8'h00;
    wire [7:0] acc, fwd, d6, d7;
    wire [4:0] fa;
    wire fwe, zf, zwe, ill;
    int error_cnt = 0;
    int comparisons = 0;
    logic [31:0] seed = 32'hd2a50bca;
    logic [31:0] r;
    logic [7:0] m_acc, m_d6, m_d7, e_fwd;
    logic [4:0] e_fa;
    logic e_fwe, e_zwe, e_z, e_ill;
    ////////////////////////////////////////////////////////////////////////
    // clock enable drops at random once the mixed traffic starts
    txo_core i_dut (.CLK(clk), .RST_N(rst_n), .CE(ce), .INSN_VALID(insn_valid),
        .INSN(insn), .FILE_RDATA(file_rdata), .STATUS_IN(status_in), .ACC(acc),
        .FILE_ADDR(fa), .FILE_WDATA(fwd), .FILE_WE(fwe), .ZERO_FLAG(zf), .ZERO_WE(zwe),
        .DIR_FIRST_PORT(d6), .SECOND_IO_PORT_DIR(d7), .ILLEGAL(ill));
    always #10 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : stop_test
    // reference model, one instruction per call; pulses default to low
    task automatic model(input logic c, input logic v, input logic [11:0] i,
        input logic [7:0] rd, input logic [7:0] st);
        logic [7:0] x;
        x = m_acc ^ (i[11:8] == 4'hf ? i[7:0] : rd);
        if (!c) return; // frozen cycle: every output holds
        {e_fwe, e_zwe, e_ill} = 3'h0;
        e_z = st[2];
        if (!v) return;
        if ((i & 12'hff8) == 12'h000) begin
            if (i[2:0] == 3'h6) m_d6 = m_acc;
            else if (i[2:0] == 3'h7) m_d7 = m_acc;
            else e_ill = (i[2:0] != 3'h0);
        end else if (i[11:8] == 4'hf || i[11:6] == 6'h06) begin
            {e_zwe, e_z} = {1'b1, x == 8'h00};
            if (i[11:8] != 4'hf && i[5]) {e_fwe, e_fa, e_fwd} = {1'b1, i[4:0], x};
            else m_acc = x;
        end
    endtask : model
    // drive now, check the instruction taken at this edge, then model this one
    task automatic step(input logic v, input logic [11:0] i, input logic [7:0] rd);
        r = xs();
        ce <= !ce_mix || (r[10:8] != 3'h0);
        insn_valid <= v;
        insn <= i;
        file_rdata <= rd;
        status_in <= r[7:0];
        @(negedge clk);
        chk(acc, m_acc);
        chk(d6, m_d6);
        chk(d7, m_d7);
        chk({7'h00, fwe}, {7'h00, e_fwe});
        if (e_fwe) chk({3'h0, fa}, {3'h0, e_fa});
        if (e_fwe) chk(fwd, e_fwd);
        chk({7'h00, zwe}, {7'h00, e_zwe});
        chk({7'h00, zf}, {7'h00, e_z});
        chk({7'h00, ill}, {7'h00, e_ill});
        model(ce, v, i, rd, status_in);
        @(posedge clk);
    endtask : step
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {m_acc, m_d6, m_d7} = {txo_pkg::ACC_RST, txo_pkg::DIR_RST, txo_pkg::DIR_RST};
        {e_fwe, e_zwe, e_ill, e_z, e_fa, e_fwd} = '0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        // literal and file xor back to back, zero result included
        step(1'b1, 12'hfb5, 8'h00);
        step(1'b1, 12'hfaf, 8'h00);
        step(1'b1, 12'h1af, 8'haf);
        step(1'b1, 12'h18f, 8'h1a);
        step(1'b1, 12'h19f, 8'h3c);
        $display("test xor done");
        // every direction target, accumulator changed between loads
        for (int t = 0; t < 8; t++) begin
            step(1'b1, 12'hf00 | 12'(t * 8'h25), 8'h00);
            step(1'b1, 12'(t), 8'h00);
        end
        $display("test direction done");
        // mixed random traffic with idle, frozen cycles and unknown opcodes
        ce_mix = 1'b1;
        repeat (300) begin
            r = xs();
            case (r[1:0])
                2'h0: step(r[4] | r[5], {9'h000, r[8:6]}, r[23:16]);
                2'h1: step(r[4] | r[5], {4'hf, r[15:8]}, r[23:16]);
                2'h2: step(r[4] | r[5], {6'h06, r[11:6]}, r[23:16]);
                default: step(r[4] | r[5], r[31:20], r[19:12]);
            endcase
        end
        step(1'b0, 12'h000, 8'h00);
        $display("test random done");
        stop_test();
    end
    initial begin
        #100000;
        error_cnt++;
        stop_test();
    end
endmodule : txo_core_test
`default_nettype wire
